// file: inc/adc_defines.vh
`ifndef ADC_DEFINES_VH
`define ADC_DEFINES_VH
`define ADDR_CTL 8'h30
`define ADDR_RES1 8'h31
`define ADDR_RES2 8'h32
`define ADDR_RES3 8'h33
`define ADDR_RES4 8'h34
`define ADDR_OPT 8'h39
`define OPT_RESET 8'h10
`define OPT_PWR 7
`define OPT_CONVERTER_CLOCK_PICK 6
`define OPT_IRQ_EDGE_PICK 5
`define OPT_DLY 4
`define OPT_CME 3
`define OPT_CLOCK_MONITOR_FORCE 2
`define OPT_PROT_MASK 8'h37
`define CTL_SCAN 5
`define CTL_MULTI_CHANNEL_PICK 4
`define PROT_WINDOW 64
`define SAMPLE_CYC 12
`define SAR_BITS 8
`define STOP_DLY_CYC 4000
`define STOP_FAST_CYC 4
`endif

// file: logic/sar_step.v
`timescale 1ns/10ps
`include "adc_defines.vh"
module sar_step (
  input wire clk,
  input wire arst_n,
  input wire ce,
  input wire start,
  input wire cmp_hi,
  output reg busy,
  output reg done,
  output reg [7:0] sar_q
);
  reg [2:0] bit_q;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy <= 1'b0;
      done <= 1'b0;
      sar_q <= 8'h00;
      bit_q <= 3'h0;
    end else if (ce) begin
      done <= 1'b0;
      if (start) begin
        busy <= 1'b1;
        bit_q <= 3'h7;
        sar_q <= 8'h80;
      end else if (busy) begin
        // keep or drop the trial bit, then try the next one down
        if (!cmp_hi)
          sar_q[bit_q] <= 1'b0;
        if (bit_q == 3'h0) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          sar_q[bit_q - 3'h1] <= 1'b1;
          bit_q <= bit_q - 3'h1;
        end
      end
    end
  end
endmodule

// file: logic/stop_delay.v
`timescale 1ns/10ps
`include "adc_defines.vh"
module stop_delay #(
  parameter LONG_CYC = `STOP_DLY_CYC
) (
  input wire clk,
  input wire arst_n,
  input wire ce,
  input wire wake,
  input wire long_dly,
  output wire running
);
  reg [12:0] cnt_q;
  assign running = (cnt_q == 13'h0000);
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      cnt_q <= 13'h0000;
    else if (ce) begin
      if (wake)
        cnt_q <= long_dly ? LONG_CYC[12:0] : 13'd`STOP_FAST_CYC;
      else if (cnt_q != 13'h0000)
        cnt_q <= cnt_q - 13'h0001;
    end
  end
endmodule

// file: logic/adc_sequence_control.v
`timescale 1ns/10ps
`include "adc_defines.vh"
module adc_sequence_control #(
  parameter CONV_CYC = 32,
  parameter STOP_CYC = `STOP_DLY_CYC
) (
  input wire clk,
  input wire arst_n,
  input wire ce,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  input wire special_mode,
  input wire cmp_hi_pin,
  input wire rc_tick,
  input wire irq_n_pin,
  input wire stop_wake,
  input wire clk_monitor_fail,
  output reg [3:0] mux_sel,
  output reg sample_sw,
  output reg [7:0] dac_code,
  output wire conv_power,
  output wire conv_clk_rc,
  output wire clk_monitor_active,
  output reg irq_req,
  output wire cpu_running
);
  localparam S_IDLE = 2'd0;
  localparam S_WAIT = 2'd1;
  localparam S_SAMP = 2'd2;
  localparam S_CONV = 2'd3;

  reg [7:0] opt_q;
  reg [6:0] prot_cnt_q;
  reg prot_done_q;
  reg [5:0] ctl_q;
  reg flag_q;
  reg [7:0] res_q [0:3];
  reg [1:0] st_q;
  reg [1:0] slot_q;
  reg [7:0] cyc_q;
  reg cmp_m_q, cmp_q, rc_m_q, rc_q, rc_d_q, irq_m_q, irq_q, irq_p_q;
  reg sar_start_q;
  wire sar_busy, sar_done;
  wire [7:0] sar_val;
  wire step_en;
  wire ctl_wr;

  function [3:0] chan_of;
    input [5:0] ctl;
    input [1:0] slot;
    begin
      if (ctl[`CTL_MULTI_CHANNEL_PICK])
        chan_of = {ctl[3:2], slot};
      else
        chan_of = ctl[3:0];
    end
  endfunction

  assign ctl_wr = wr && (addr == `ADDR_CTL);
  assign conv_power = opt_q[`OPT_PWR];
  assign conv_clk_rc = opt_q[`OPT_CONVERTER_CLOCK_PICK];
  // rc mode steps on a synchronised oscillator edge, else every clock
  assign step_en = conv_clk_rc ? (rc_q & ~rc_d_q) : 1'b1;
  assign clk_monitor_active = opt_q[`OPT_CLOCK_MONITOR_FORCE] | opt_q[`OPT_CME];

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmp_m_q <= 1'b0;
      cmp_q <= 1'b0;
      rc_m_q <= 1'b0;
      rc_q <= 1'b0;
      rc_d_q <= 1'b0;
      irq_m_q <= 1'b1;
      irq_q <= 1'b1;
      irq_p_q <= 1'b1;
    end else if (ce) begin
      cmp_m_q <= cmp_hi_pin;
      cmp_q <= cmp_m_q;
      rc_m_q <= rc_tick;
      rc_q <= rc_m_q;
      rc_d_q <= rc_q;
      irq_m_q <= irq_n_pin;
      irq_q <= irq_m_q;
      irq_p_q <= irq_q;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      irq_req <= 1'b0;
    else if (ce) begin
      if (opt_q[`OPT_IRQ_EDGE_PICK])
        irq_req <= irq_p_q & ~irq_q;
      else
        irq_req <= ~irq_q;
    end
  end

  // options register with write-once window for protected bits
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      opt_q <= `OPT_RESET;
      prot_cnt_q <= 7'h00;
      prot_done_q <= 1'b0;
    end else if (ce) begin
      if (prot_cnt_q != `PROT_WINDOW)
        prot_cnt_q <= prot_cnt_q + 7'h01;
      if (wr && addr == `ADDR_OPT) begin
        if (special_mode ||
            (!prot_done_q && prot_cnt_q != `PROT_WINDOW)) begin
          opt_q <= wdata;
          prot_done_q <= 1'b1;
        end else
          opt_q <= (opt_q & `OPT_PROT_MASK) |
                   (wdata & ~`OPT_PROT_MASK);
        // forced monitor cannot be cleared once set
        if (opt_q[`OPT_CLOCK_MONITOR_FORCE])
          opt_q[`OPT_CLOCK_MONITOR_FORCE] <= 1'b1;
      end
    end
  end

  stop_delay #(
    .LONG_CYC(STOP_CYC)
  ) u_stop (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .wake(stop_wake),
    .long_dly(opt_q[`OPT_DLY]),
    .running(cpu_running)
  );

  sar_step u_sar (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce & step_en),
    .start(sar_start_q),
    .cmp_hi(cmp_q),
    .busy(sar_busy),
    .done(sar_done),
    .sar_q(sar_val)
  );

  // sequencer; a control write aborts anything in flight
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= S_IDLE;
      ctl_q <= 6'h00;
      flag_q <= 1'b0;
      slot_q <= 2'h0;
      cyc_q <= 8'h00;
      sar_start_q <= 1'b0;
      sample_sw <= 1'b0;
      mux_sel <= 4'h0;
      dac_code <= 8'h00;
      res_q[0] <= 8'h00;
      res_q[1] <= 8'h00;
      res_q[2] <= 8'h00;
      res_q[3] <= 8'h00;
    end else if (ce) begin
      sar_start_q <= 1'b0;
      dac_code <= sar_val;
      if (!conv_power) begin
        st_q <= S_IDLE;
        sample_sw <= 1'b0;
      end else if (ctl_wr) begin
        ctl_q <= wdata[5:0];
        flag_q <= 1'b0;
        slot_q <= 2'h0;
        sample_sw <= 1'b0;
        st_q <= S_WAIT;
      end else begin
        case (st_q)
          S_IDLE: begin
          end
          S_WAIT: begin
            mux_sel <= chan_of(ctl_q, slot_q);
            sample_sw <= 1'b1;
            cyc_q <= 8'h00;
            st_q <= S_SAMP;
          end
          S_SAMP: begin
            if (step_en) begin
              if (cyc_q == `SAMPLE_CYC - 1) begin
                sample_sw <= 1'b0;
                sar_start_q <= 1'b1;
                cyc_q <= 8'h00;
                st_q <= S_CONV;
              end else
                cyc_q <= cyc_q + 8'h01;
            end
          end
          S_CONV: begin
            // count steps up to CONV_CYC; the exit waits on sar_done alone
            if (step_en && cyc_q != CONV_CYC[7:0])
              cyc_q <= cyc_q + 8'h01;
            if (sar_done) begin
              res_q[slot_q] <= sar_val;
              slot_q <= slot_q + 2'h1;
              if (slot_q == 2'h3) begin
                flag_q <= 1'b1;
                if (ctl_q[`CTL_SCAN])
                  st_q <= S_WAIT;
                else
                  st_q <= S_IDLE;
              end else
                st_q <= S_WAIT;
            end
          end
          default: st_q <= S_IDLE;
        endcase
      end
    end
  end

  // reads sample the slot before this edge's update lands
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      rdata <= 8'h00;
    else if (ce) begin
      if (!rd)
        rdata <= 8'h00;
      else if (addr == `ADDR_CTL)
        rdata <= {flag_q, 1'b0, ctl_q};
      else if (addr == `ADDR_RES1)
        rdata <= res_q[0];
      else if (addr == `ADDR_RES2)
        rdata <= res_q[1];
      else if (addr == `ADDR_RES3)
        rdata <= res_q[2];
      else if (addr == `ADDR_RES4)
        rdata <= res_q[3];
      else if (addr == `ADDR_OPT)
        rdata <= opt_q;
      else
        rdata <= 8'h00;
    end
  end
endmodule

// file: dv/adc_seq_checker.sv
`timescale 1ns/10ps
`include "adc_defines.vh"
module adc_seq_checker (
  input clk,
  input arst_n,
  input [7:0] addr,
  input wr,
  input rd,
  input [7:0] rdata,
  input [3:0] mux_sel,
  input sample_sw,
  input [7:0] dac_code,
  input conv_power,
  input conv_clk_rc
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // count closed cycles rather than unroll a long repetition
  logic [4:0] sw_run_q;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      sw_run_q <= 5'd0;
    else if (!sample_sw)
      sw_run_q <= 5'd0;
    else if (sw_run_q != 5'd31)
      sw_run_q <= sw_run_q + 5'd1;
  end
  sequence s_sample_end;
    $fell(sample_sw) && !$past(wr);
  endsequence
  sequence s_launch;
    !sample_sw ##1 sample_sw;
  endsequence
  chk_start_delay: assert property (
    wr && addr == `ADDR_CTL && conv_power |-> ##1 s_launch)
    else $error("sampling did not start one cycle after control write");
  // a control write aborts the window, so it cancels the attempt
  chk_sample_len: assert property (
    s_sample_end |-> sw_run_q == 5'd12)
    else $error("sample window not twelve cycles");
  chk_mux_steady: assert property (
    sample_sw && $past(sample_sw) |-> $stable(mux_sel))
    else $error("channel changed inside sample window");
  chk_msb_first: assert property (
    $fell(sample_sw) && !$past(wr) && conv_power |-> ##[0:3] dac_code == 8'h80)
    else $error("first trial code is not msb");
  chk_rd_quiet: assert property (
    !$past(rd) |-> rdata == 8'h00)
    else $error("read data outside its cycle");
  chk_idle_unpowered: assert property (
    !conv_power && !$past(conv_power) |-> !sample_sw)
    else $error("sampling while unpowered");
  chk_power_src: assert property (
    $changed(conv_power) |-> $past(wr && addr == `ADDR_OPT))
    else $error("power changed without option write");
  chk_clk_src: assert property (
    $changed(conv_clk_rc) |-> $past(wr && addr == `ADDR_OPT))
    else $error("clock pick changed without option write");
endmodule
bind adc_sequence_control adc_seq_checker i_chk (.clk(clk), .arst_n(arst_n),
  .addr(addr), .wr(wr), .rd(rd), .rdata(rdata), .mux_sel(mux_sel),
  .sample_sw(sample_sw), .dac_code(dac_code), .conv_power(conv_power),
  .conv_clk_rc(conv_clk_rc));

// file: dv/adc_sequence_control_bench.sv
`timescale 1ns/10ps
`include "adc_defines.vh"
module adc_sequence_control_bench;
  logic clk = 0, arst_n = 0, wr = 0, rd = 0, cmp_hi_pin = 0, irq_n_pin = 1;
  logic stop_wake = 0, cpu_running;
  logic [7:0] addr = 8'h00, wdata = 8'h00, v, rdata, dac_code;
  logic [3:0] mux_sel, ch;
  logic sample_sw, conv_power, conv_clk_rc, irq_req;
  int err_count = 0, checks_done = 0, seed = 20, n, m;
  // 20 MHz stays well above the point where the rc clock is needed
  always #25 clk = ~clk;
  adc_sequence_control #(.STOP_CYC(20)) i_dut (.clk(clk), .arst_n(arst_n),
    .ce(1'b1), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .special_mode(1'b0), .cmp_hi_pin(cmp_hi_pin), .rc_tick(1'b0),
    .irq_n_pin(irq_n_pin), .stop_wake(stop_wake), .clk_monitor_fail(1'b0),
    .mux_sel(mux_sel), .sample_sw(sample_sw), .dac_code(dac_code),
    .conv_power(conv_power), .conv_clk_rc(conv_clk_rc),
    .clk_monitor_active(), .irq_req(irq_req), .cpu_running(cpu_running));
  // inputs sit at zero or full scale, so comparator sync lag cannot matter
  function automatic logic [7:0] level(input logic [3:0] c);
    return (c[0] ^ c[2]) ? 8'hFF : 8'h00;
  endfunction
  // the bench never reads the shared input pins digitally
  always @(posedge clk) cmp_hi_pin <= mux_sel[0] ^ mux_sel[2];
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
    #1;
  endtask
  task rreg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1 v = rdata;
  endtask
  task count_sw;
    n = 0;
    repeat (200) begin
      @(posedge clk) #1;
      n += sample_sw;
    end
  endtask
  task run(input logic [7:0] c);
    wreg(`ADDR_CTL, c);
    rreg(`ADDR_CTL);
    chk("ctl start", v, {2'b00, c[5:0]});
    n = 0;
    do begin
      rreg(`ADDR_CTL);
      n++;
    end while (v[7] !== 1'b1 && n < 400);
    chk("ctl done", v, {2'b10, c[5:0]});
    for (int i = 0; i < 4; i++) begin
      rreg(`ADDR_RES1 + 8'(i));
      chk("slot", v, level(c[4] ? {c[3:2], 2'(i)} : c[3:0]));
    end
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #2000000;
    err_count++;
    give_verdict;
  end
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1;
    rreg(`ADDR_OPT);
    chk("opt reset", v, `OPT_RESET);
    wreg(`ADDR_OPT, 8'hA1);
    wreg(`ADDR_OPT, 8'h90);
    rreg(`ADDR_OPT);
    chk("opt", v, 8'hA1);
    chk("power", {7'h00, conv_power}, 8'h01);
    repeat (2000) @(posedge clk);
    rreg(8'h35);
    chk("unmapped", v, 8'h00);
    for (m = 0; m < 2; m++) begin
      ch = 4'($random(seed));
      run({3'b000, m[0], ch});
      count_sw;
      chk("halt", 8'(n), 8'h00);
    end
    ch = 4'($random(seed));
    run({4'b0011, ch});
    count_sw;
    chk("scan", {7'h00, n > 0}, 8'h01);
    run({4'b0000, ch});
    @(posedge clk);
    irq_n_pin <= 0;
    n = 0;
    repeat (30) begin
      @(posedge clk) #1;
      n += irq_req;
    end
    irq_n_pin <= 1;
    chk("irq pulses", 8'(n), 8'h01);
    @(posedge clk);
    stop_wake <= 1;
    @(posedge clk);
    stop_wake <= 0;
    #1 chk("stop hold", {7'h00, cpu_running}, 8'h00);
    repeat (6) @(posedge clk);
    #1 chk("stop resume", {7'h00, cpu_running}, 8'h01);
    wreg(`ADDR_OPT, 8'h41);
    chk("rc pick", {7'h00, conv_clk_rc}, 8'h01);
    wreg(`ADDR_CTL, 8'h03);
    count_sw;
    chk("unpowered", 8'(n), 8'h00);
    give_verdict;
  end
endmodule
